/* shared/pgs_pkg.sv */
// constants and types shared by the power-good supervisor
package pgs_pkg;
	localparam int SENSE_W = 12;
	localparam int PCT_FULL = 100;
	localparam logic [1:0] LEVEL_RESET = 2'h2;
	localparam logic MODE_RESET = 1'h1;
	localparam logic MODE_THRESHOLD = 1'h1;
	localparam logic MODE_RAMP = 1'h0;
	localparam logic [6:0] PCT_L0 = 7'h50;
	localparam logic [6:0] PCT_L1 = 7'h55;
	localparam logic [6:0] PCT_L2 = 7'h5A;
	localparam logic [6:0] PCT_L3 = 7'h5F;
	localparam logic [6:0] HYST_PCT = 7'h05;
	localparam logic [6:0] RAMP_NEAR_PCT = 7'h02;
	localparam int SYNC_BITS = 7;
	typedef enum logic [3:0] {
		PGS_OFF = 4'h1,
		PGS_START = 4'h2,
		PGS_GOOD = 4'h4,
		PGS_LOW = 4'h8
	} pgs_state_t;
endpackage

/* logic/pgs_sync.sv */
// two-flop synchroniser bank for the comparator, enable, bias and fault levels
`timescale 1ns/100ps
module pgs_sync #(
	parameter int WIDTH = 7
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	// first stage feeds only the second stage
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_r;
			always_ff @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					meta_r <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_r <= async_in[i];
					sync_out[i] <= meta_r;
				end
			end
		end
	endgenerate
endmodule

/* logic/pgs_top.sv */
// power-good supervisor: thresholds, start-up modes and open-drain output
`timescale 1ns/100ps
// Function
// R01: the lower threshold sits 5% below the selected upper threshold percentage of target.
// R02: power good releases high when the sense voltage passes the upper threshold.
// R03: power good drives low when the sense voltage drops under the lower threshold.
// R04: in mode 1, the default, start-up and regulation use the same assertion behaviour.
// R05: power good needs enable and bias ok, no fault, and sense above threshold.
// R06: in mode 0, behaviour after start-up equals mode 1.
// R07: in mode 0 start-up asserts once the soft-start ramp is within 2% of target.
// R08: in mode 0 with a pre-biased output, power good waits for the first high-side gate pulse.
// R09: the output stays driven low even when the bias supply is low.
// R10: level select 0,1,2,3 means 80,85,90,95 percent, 2 after reset.
// R11: mode select 1 is threshold based and reset default, 0 is ramp based.
// R12: an over-current fault pulls power good and soft-start low.
// R13: comparator, supply and fault levels are synchronised before use.
module pgs_top #(
	parameter int SENSE_W = pgs_pkg::SENSE_W
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [SENSE_W-1:0] output_sense_voltage,
	input wire logic [SENSE_W-1:0] target_voltage,
	input wire logic [SENSE_W-1:0] soft_start_ramp,
	input wire logic [1:0] good_level_select,
	input wire logic good_mode_select,
	input wire logic enable_ok,
	input wire logic bias_ok,
	input wire logic fault_overcurrent,
	input wire logic fault_overvoltage,
	input wire logic fault_overtemp,
	input wire logic pre_biased,
	input wire logic high_side_gate,
	output logic power_good_out_o,
	output logic power_good_out_oe,
	output logic soft_start_hold_n
);
	import pgs_pkg::*;

	// a sense code times a percentage up to 100 needs seven more bits
	localparam int PROD_W = SENSE_W + 7;

	// threshold arithmetic, all combinational
	logic [6:0] upper_pct;
	logic [6:0] lower_pct;
	logic [PROD_W-1:0] sense_scaled;
	logic [PROD_W-1:0] upper_lim;
	logic [PROD_W-1:0] lower_lim;
	logic [PROD_W-1:0] ramp_scaled;
	logic [PROD_W-1:0] ramp_lim;
	logic above_upper;
	logic below_lower;
	logic ramp_near;

	// decision levels before and after the synchroniser
	logic [SYNC_BITS-1:0] raw_lv;
	logic [SYNC_BITS-1:0] syn_lv;
	logic s_above;
	logic s_below;
	logic s_ramp;
	logic s_en;
	logic s_bias;
	logic s_fault;
	logic s_oc;

	// registered settings and sequence state
	logic [1:0] level_r;
	logic mode_r;
	logic gate_seen_r;
	pgs_state_t state_r;
	pgs_state_t state_nxt;
	logic good_nxt;

	// map level select to percent of target
	always_comb
	begin
		case (level_r)
			2'h0: upper_pct = PCT_L0; // R10
			2'h1: upper_pct = PCT_L1; // R10
			2'h2: upper_pct = PCT_L2; // R10
			2'h3: upper_pct = PCT_L3; // R10
			default: upper_pct = PCT_L2;
		endcase
	end

	// compare in percent units: sense*100 against target*pct avoids a divider
	assign lower_pct = upper_pct - HYST_PCT; // R01
	assign sense_scaled = PROD_W'(output_sense_voltage) * PROD_W'(PCT_FULL);
	assign upper_lim = PROD_W'(target_voltage) * PROD_W'(upper_pct);
	assign lower_lim = PROD_W'(target_voltage) * PROD_W'(lower_pct); // R01
	assign ramp_scaled = PROD_W'(soft_start_ramp) * PROD_W'(PCT_FULL);
	assign ramp_lim = PROD_W'(target_voltage) * PROD_W'(7'(PCT_FULL) - RAMP_NEAR_PCT);
	assign above_upper = sense_scaled > upper_lim; // R02
	assign below_lower = sense_scaled < lower_lim; // R03
	assign ramp_near = ramp_scaled >= ramp_lim; // R07

	// comparator, enable, bias and fault levels cross a two-flop synchroniser; pre_biased and high_side_gate do not
	assign raw_lv = {above_upper, below_lower, ramp_near, enable_ok, bias_ok,
		fault_overvoltage | fault_overtemp | fault_overcurrent, fault_overcurrent};

	pgs_sync #(
		.WIDTH(SYNC_BITS)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in(raw_lv),
		.sync_out(syn_lv)
	); // R13

	assign {s_above, s_below, s_ramp, s_en, s_bias, s_fault, s_oc} = syn_lv;

	// settings sampled every cycle; reset gives the documented defaults
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			level_r <= LEVEL_RESET; // R10
			mode_r <= MODE_RESET; // R11
		end
		else
		begin
			level_r <= good_level_select;
			mode_r <= good_mode_select;
		end
	end

	// remember the first high-side gate pulse of this start-up
	// a pulse while OFF is ignored: only gating of the current start-up counts
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			gate_seen_r <= 1'b0;
		else if (state_r == PGS_OFF)
			gate_seen_r <= 1'b0;
		else if (high_side_gate)
			gate_seen_r <= 1'b1; // R08
	end

	// start-up / regulation sequence
	always_comb
	begin
		state_nxt = state_r;
		good_nxt = 1'b0;
		case (state_r)
			PGS_OFF:
			begin
				if (s_en && s_bias && !s_fault)
					state_nxt = PGS_START;
			end
			PGS_START:
			begin
				if (!(s_en && s_bias) || s_fault)
					state_nxt = PGS_OFF; // R05
				else if (mode_r == MODE_THRESHOLD)
				begin
					if (s_above)
						state_nxt = PGS_GOOD; // R02 R04
				end
				else if (s_ramp && (!pre_biased || gate_seen_r || high_side_gate))
					state_nxt = PGS_GOOD; // R07 R08 R11
			end
			PGS_GOOD:
			begin
				if (!(s_en && s_bias) || s_fault)
					state_nxt = PGS_OFF; // R05 R12
				else if (s_below)
					state_nxt = PGS_LOW; // R03 R06
				else
					good_nxt = 1'b1; // R05
			end
			PGS_LOW:
			begin
				// regulation reached: both modes use the threshold here
				if (!(s_en && s_bias) || s_fault)
					state_nxt = PGS_OFF;
				else if (s_above)
				begin
					state_nxt = PGS_GOOD; // R02 R06
					good_nxt = 1'b1;
				end
			end
			// a corrupted code falls back to OFF, which keeps the line pulled low
			default: state_nxt = PGS_OFF;
		endcase
		// entering GOOD releases the line on the same edge the state moves
		if (state_nxt == PGS_GOOD && state_r != PGS_GOOD)
			good_nxt = 1'b1;
	end

	// sequence state; reset parks it in OFF with the line pulled low
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			state_r <= PGS_OFF;
		else
			state_r <= state_nxt;
	end

	// open drain: enable high pulls low; released means line pulled up outside
	// the data bit never leaves low, so the pin cannot fight an outside pull-up rail
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			power_good_out_o <= 1'b0;
			power_good_out_oe <= 1'b1; // R09
		end
		else
		begin
			power_good_out_o <= 1'b0;
			power_good_out_oe <= !good_nxt; // R09
		end
	end

	// over-current collapses the soft-start ramp too
	// the hold lifts three clock edges after the fault clears: two synchroniser stages and this flop
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			soft_start_hold_n <= 1'b0;
		else
			soft_start_hold_n <= !s_oc; // R12
	end
endmodule

/* bench/pgs_sva.sv */
// checker for the power-good supervisor ports
`timescale 1ns/100ps
module pgs_chk #(
	parameter int SENSE_W = 12
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [SENSE_W-1:0] output_sense_voltage,
	input wire logic [SENSE_W-1:0] target_voltage,
	input wire logic [1:0] good_level_select,
	input wire logic good_mode_select,
	input wire logic enable_ok,
	input wire logic bias_ok,
	input wire logic fault_overcurrent,
	input wire logic fault_overvoltage,
	input wire logic fault_overtemp,
	input wire logic power_good_out_o,
	input wire logic power_good_out_oe,
	input wire logic soft_start_hold_n
);
	int pct;
	int sv;
	int tv;
	logic ok;
	logic hi;
	logic lo;
	// thresholds redone here so a wrong encoding shows up
	assign pct = 80 + 5 * int'(good_level_select);
	assign sv = 100 * int'(output_sense_voltage);
	assign tv = int'(target_voltage);
	assign hi = sv > pct * tv;
	assign lo = sv < (pct - 5) * tv;
	assign ok = enable_ok & bias_ok & ~fault_overcurrent & ~fault_overvoltage & ~fault_overtemp;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// held long enough to cover sync and state steps
	sequence s_up; (ok & hi & good_mode_select) [*8]; endsequence
	sequence s_dn; (lo & good_mode_select) [*6]; endsequence
	property p_low; power_good_out_o == 1'b0; endproperty
	property p_up; s_up |-> !power_good_out_oe; endproperty
	property p_dn; s_dn |-> power_good_out_oe; endproperty
	property p_oc; fault_overcurrent |-> ##[1:4] (power_good_out_oe & !soft_start_hold_n); endproperty
	property p_en; !enable_ok |-> ##[1:4] power_good_out_oe; endproperty
	property p_bias; !bias_ok |-> ##[1:4] power_good_out_oe; endproperty
	property p_ov; fault_overvoltage |-> ##[1:4] power_good_out_oe; endproperty
	property p_ot; fault_overtemp |-> ##[1:4] power_good_out_oe; endproperty
	a_low: assert property (p_low) else $error("pin data high");
	a_up: assert property (p_up) else $error("no release");
	a_dn: assert property (p_dn) else $error("no pull low");
	a_oc: assert property (p_oc) else $error("overcurrent");
	a_en: assert property (p_en) else $error("enable");
	a_bias: assert property (p_bias) else $error("bias");
	a_ov: assert property (p_ov) else $error("overvoltage");
	a_ot: assert property (p_ot) else $error("overtemp");
endmodule
bind pgs_top pgs_chk #(.SENSE_W(SENSE_W)) u_chk (.core_clk, .reset, .output_sense_voltage,
	.target_voltage, .good_level_select, .good_mode_select, .enable_ok, .bias_ok,
	.fault_overcurrent, .fault_overvoltage, .fault_overtemp, .power_good_out_o,
	.power_good_out_oe, .soft_start_hold_n);

/* bench/pgs_line_model.sv */
// pulled-up power-good line as seen by the sequencing logic
`timescale 1ns/100ps
module pgs_line_model (
	input wire logic power_good_out_o,
	input wire logic power_good_out_oe,
	output logic pg_line
);
	// the external pull-up wins whenever the pin is released
	assign pg_line = power_good_out_oe ? power_good_out_o : 1'b1;
endmodule

/* bench/testbench.sv */
// self-checking bench for the power-good supervisor
`timescale 1ns/100ps
module testbench;
	import pgs_pkg::*;
	logic core_clk = 0, reset = 1, mode = 1, pre = 0, gate = 0, pg_line, pg_o, pg_oe, ss_n;
	logic [4:0] bad = 5'h00;
	logic [1:0] lev = 2'h2;
	logic [SENSE_W-1:0] sense = 12'h000, tgt = 12'h3E8, ramp = 12'h000;
	int n_fail = 0, num_checks = 0;
	int pt[4] = '{PCT_L0, PCT_L1, PCT_L2, PCT_L3};
	always #10 core_clk = ~core_clk;
	pgs_top u_dut (.core_clk, .reset, .output_sense_voltage(sense), .target_voltage(tgt),
		.soft_start_ramp(ramp), .good_level_select(lev), .good_mode_select(mode),
		.enable_ok(~bad[0]), .bias_ok(~bad[1]), .fault_overcurrent(bad[2]),
		.fault_overvoltage(bad[3]), .fault_overtemp(bad[4]), .pre_biased(pre),
		.high_side_gate(gate), .power_good_out_o(pg_o), .power_good_out_oe(pg_oe),
		.soft_start_hold_n(ss_n));
	pgs_line_model u_line (.power_good_out_o(pg_o), .power_good_out_oe(pg_oe), .pg_line);
	task automatic tally_and_finish;
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask
	// settle well past the sync latency, then look at the line
	task automatic see(input logic e);
		repeat (8) @(negedge core_clk);
		chk("pg_line", e, pg_line);
	endtask
	task automatic put(input int s);
		@(posedge core_clk);
		sense <= SENSE_W'(s);
	endtask
	task automatic t_levels;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			lev <= 2'(i);
			put(10 * pt[i]);
			see(1'b0);
			put(10 * pt[i] + 1);
			see(1'b1);
			put(10 * (pt[i] - HYST_PCT) + 1);
			see(1'b1);
			put(10 * (pt[i] - HYST_PCT) - 1);
			see(1'b0);
		end
	endtask
	task automatic t_gates;
		for (int i = 0; i < 5; i++)
		begin
			put(1000);
			see(1'b1);
			@(posedge core_clk);
			bad <= 5'(1 << i);
			see(1'b0);
			chk("ss_n", i != 2, ss_n);
			@(posedge core_clk);
			bad <= 5'h00;
		end
	endtask
	task automatic t_ramp;
		@(posedge core_clk);
		bad <= 5'h01;
		lev <= 2'h2;
		put(870);
		ramp <= 12'h3D4;
		see(1'b0);
		@(posedge core_clk);
		bad <= 5'h00;
		see(1'b0);
		@(posedge core_clk);
		bad <= 5'h01;
		mode <= 1'b0;
		ramp <= 12'h3C9;
		sense <= 12'h3B6;
		see(1'b0);
		@(posedge core_clk);
		bad <= 5'h00;
		see(1'b0);
		@(posedge core_clk);
		ramp <= 12'h3D4;
		see(1'b1);
		put(849);
		see(1'b0);
		put(901);
		see(1'b1);
		@(posedge core_clk);
		bad <= 5'h01;
		pre <= 1'b1;
		put(870);
		see(1'b0);
		@(posedge core_clk);
		bad <= 5'h00;
		see(1'b0);
		@(posedge core_clk);
		gate <= 1'b1;
		@(posedge core_clk);
		gate <= 1'b0;
		see(1'b1);
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		chk("pg_oe", 1'b1, pg_oe);
		reset <= 1'b0;
		t_levels();
		t_gates();
		t_ramp();
		tally_and_finish();
	end
	// a hang is cut short well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (5000) @(posedge core_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule
